// *** cpuev_pkg.sv ***
// Package of event ranks, handler offsets and address constants for the event entry unit
package cpuev_pkg;
   localparam int ADDR_W = 32;
   localparam logic [31:0] RESET_ADDR = 32'h8000_0000;
   localparam int AUTOVEC_W = 14;
   localparam int NUM_EV = 28;
   localparam int RANK_W = 5;
   localparam logic [31:0] SCALL_RET_INC = 32'h0000_0002;
   // Event index equals rank minus one
   localparam int EV_RESET = 0;
   localparam int EV_DEBUG = 1;
   localparam int EV_UNREC = 2;
   localparam int EV_MULTI = 3;
   localparam int EV_BUS_D = 4;
   localparam int EV_BUS_I = 5;
   localparam int EV_NMI = 6;
   localparam int EV_INTERRUPT_LEVEL_THREE = 7;
   localparam int EV_INT2 = 8;
   localparam int EV_INT1 = 9;
   localparam int EV_INTERRUPT_LEVEL_ZERO = 10;
   localparam int EV_IADDR = 11;
   localparam int EV_IMISS = 12;
   localparam int EV_IPROT = 13;
   localparam int EV_BRK = 14;
   localparam int EV_ILL = 15;
   localparam int EV_UNIMP = 16;
   localparam int EV_PRIV = 17;
   localparam int EV_FPU = 18;
   localparam int EV_COP = 19;
   localparam int EV_SCALL = 20;
   localparam int EV_DA_RD = 21;
   localparam int EV_DA_WR = 22;
   localparam int EV_DMISS_RD = 23;
   localparam int EV_DMISS_WR = 24;
   localparam int EV_DPROT_RD = 25;
   localparam int EV_DPROT_WR = 26;
   localparam int EV_DMOD = 27;
   localparam logic [31:0] OFF_UNREC = 32'h0000_0000;
   localparam logic [31:0] OFF_MULTI = 32'h0000_0004;
   localparam logic [31:0] OFF_BUS_D = 32'h0000_0008;
   localparam logic [31:0] OFF_BUS_I = 32'h0000_000C;
   localparam logic [31:0] OFF_NMI = 32'h0000_0010;
   localparam logic [31:0] OFF_IADDR = 32'h0000_0014;
   localparam logic [31:0] OFF_IMISS = 32'h0000_0050;
   localparam logic [31:0] OFF_IPROT = 32'h0000_0018;
   localparam logic [31:0] OFF_BRK = 32'h0000_001C;
   localparam logic [31:0] OFF_ILL = 32'h0000_0020;
   localparam logic [31:0] OFF_UNIMP = 32'h0000_0024;
   localparam logic [31:0] OFF_PRIV = 32'h0000_0028;
   localparam logic [31:0] OFF_FPU = 32'h0000_002C;
   localparam logic [31:0] OFF_COP = 32'h0000_0030;
   localparam logic [31:0] OFF_SCALL = 32'h0000_0100;
   localparam logic [31:0] OFF_DA_RD = 32'h0000_0034;
   localparam logic [31:0] OFF_DA_WR = 32'h0000_0038;
   localparam logic [31:0] OFF_DMISS_RD = 32'h0000_0060;
   localparam logic [31:0] OFF_DMISS_WR = 32'h0000_0070;
   localparam logic [31:0] OFF_DPROT_RD = 32'h0000_003C;
   localparam logic [31:0] OFF_DPROT_WR = 32'h0000_0040;
   localparam logic [31:0] OFF_DMOD = 32'h0000_0044;
   // Mask bit positions: interrupt levels 0..3, exceptions, global
   localparam int MASK_W = 6;
   localparam int MB_I0 = 0;
   localparam int MB_I1 = 1;
   localparam int MB_I2 = 2;
   localparam int MB_I3 = 3;
   localparam int MB_EXC = 4;
   localparam int MB_GLB = 5;
   typedef enum logic [1:0] {
      CPUEV_RET_NONE,
      CPUEV_RET_FAULT,
      CPUEV_RET_NEXT,
      CPUEV_RET_SCALL
   } cpuev_ret_t;
endpackage

// *** cpuev_pick.sv ***
// Fixed-priority picker over one instruction's pending events
`timescale 1ns/1ps
module cpuev_pick #(
   parameter int N = cpuev_pkg::NUM_EV
) (
   input wire logic [N-1:0] pend,
   output logic any,
   output logic [cpuev_pkg::RANK_W-1:0] idx
);
   import cpuev_pkg::*;
   // Lowest index is best rank; scan downward so the best wins last
   always_comb begin
      any = 1'b0;
      idx = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (pend[i]) begin
            any = 1'b1;
            idx = RANK_W'(i);
         end
      end
   end
endmodule // cpuev_pick

// *** cpuev_entry.sv ***
// Event selection and handler entry address generation for the CPU core
// Functional notes
// - After reset fetch starts at fixed boot flash address, ignoring the vector base.
// - Translation misses and supervisor call get enlarged handler spaces.
// - Every non-interrupt exception has its own distinct entry offset.
// - Protection violations split into instruction-side and data-side exceptions.
// - Accesses matching no region raise instruction-side or data-side miss.
// - Accesses matching several regions raise the multiple-hit exception.
// - Interrupt controller supplies the interrupt handler offset from the vector base.
// - The interrupt offset is fourteen address bits wide.
// - Among one instruction's events only the best fixed rank is taken.
// - Oldest instruction's events are handled before any younger instruction's.
// - Age follows issue order; later issued means younger.
// - Reset ranks first; debug stop second using debug entry address.
// - Unrecoverable at 0x00, multiple hit at 0x04, return to faulting instruction.
// - Bus errors and NMI at 0x08, 0x0C, 0x10, return to next unfinished.
// - Interrupt levels rank 8 to 11, level three highest, autovectored.
// - Instruction address, miss, protection and breakpoint entries and ranks.
// - Illegal, unimplemented, privilege and coprocessor absent entries, return to offender.
// - Supervisor call ranks 21 at 0x100, returns to call address plus two.
// - Misaligned read at 0x34, write at 0x38, return to offender.
// - Data miss read/write at 0x60/0x70, protection read/write at 0x3C/0x40.
// - Floating-point and data-modified slots are never raised.
// - Target is vector base OR offset, never a sum.
// - Accepting an interrupt masks its own and lower levels plus global; other events except reset and debug set all mask bits; critical events stay unmaskable.
`timescale 1ns/1ps
module cpuev_entry #(
   parameter int STAGES = 3
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [cpuev_pkg::ADDR_W-1:0] event_vector_base,
   input wire logic [STAGES-1:0] stage_valid,
   input wire logic [STAGES*cpuev_pkg::ADDR_W-1:0] stage_pc,
   input wire logic [STAGES-1:0] stage_illegal,
   input wire logic [STAGES-1:0] stage_unimpl,
   input wire logic [STAGES-1:0] stage_priv,
   input wire logic [STAGES-1:0] stage_cop_absent,
   input wire logic [STAGES-1:0] stage_scall,
   input wire logic [STAGES-1:0] stage_iaddr,
   input wire logic [STAGES-1:0] stage_daddr_rd,
   input wire logic [STAGES-1:0] stage_daddr_wr,
   input wire logic [STAGES-1:0] stage_unrec,
   input wire logic [STAGES-1:0] stage_breakpoint,
   input wire logic [STAGES-1:0] stage_mpu_check,
   input wire logic [STAGES-1:0] stage_mpu_fetch,
   input wire logic [STAGES-1:0] stage_mpu_write,
   input wire logic [STAGES-1:0] stage_mpu_nohit,
   input wire logic [STAGES-1:0] stage_mpu_multi,
   input wire logic [STAGES-1:0] stage_mpu_denied,
   input wire logic [STAGES-1:0] stage_bus_err_d,
   input wire logic [STAGES-1:0] stage_bus_err_i,
   input wire logic [cpuev_pkg::ADDR_W-1:0] next_unfinished_pc,
   input wire logic nmi_req,
   input wire logic [3:0] irq_level_req,
   input wire logic [cpuev_pkg::AUTOVEC_W-1:0] irq_offset,
   input wire logic on_chip_debug_stop,
   input wire logic [cpuev_pkg::ADDR_W-1:0] on_chip_debug_entry,
   input wire logic [cpuev_pkg::MASK_W-1:0] mask_in,
   input wire logic debug_mask,
   output logic redirect,
   output logic [cpuev_pkg::ADDR_W-1:0] redirect_addr,
   output logic [cpuev_pkg::ADDR_W-1:0] return_addr,
   output logic [cpuev_pkg::RANK_W-1:0] taken_event,
   output logic [cpuev_pkg::MASK_W-1:0] mask_set,
   output logic [STAGES-1:0] flush_stage
);
   import cpuev_pkg::*;

   // handler offsets
   // Handler offset of an event index; interrupts and debug are handled apart
   function automatic logic [31:0] ev_offset(input logic [RANK_W-1:0] e);
      case (int'(e))
         EV_UNREC: ev_offset = OFF_UNREC;
         EV_MULTI: ev_offset = OFF_MULTI;
         EV_BUS_D: ev_offset = OFF_BUS_D;
         EV_BUS_I: ev_offset = OFF_BUS_I;
         EV_NMI: ev_offset = OFF_NMI;
         EV_IADDR: ev_offset = OFF_IADDR;
         EV_IMISS: ev_offset = OFF_IMISS;
         EV_IPROT: ev_offset = OFF_IPROT;
         EV_BRK: ev_offset = OFF_BRK;
         EV_ILL: ev_offset = OFF_ILL;
         EV_UNIMP: ev_offset = OFF_UNIMP;
         EV_PRIV: ev_offset = OFF_PRIV;
         EV_FPU: ev_offset = OFF_FPU;
         EV_COP: ev_offset = OFF_COP;
         EV_SCALL: ev_offset = OFF_SCALL;
         EV_DA_RD: ev_offset = OFF_DA_RD;
         EV_DA_WR: ev_offset = OFF_DA_WR;
         EV_DMISS_RD: ev_offset = OFF_DMISS_RD;
         EV_DMISS_WR: ev_offset = OFF_DMISS_WR;
         EV_DPROT_RD: ev_offset = OFF_DPROT_RD;
         EV_DPROT_WR: ev_offset = OFF_DPROT_WR;
         default: ev_offset = OFF_DMOD;
      endcase
   endfunction

   // Which return point an event stores
   function automatic cpuev_ret_t ev_ret(input logic [RANK_W-1:0] e);
      if (int'(e) == EV_RESET)
         ev_ret = CPUEV_RET_NONE;
      else if (int'(e) == EV_SCALL)
         ev_ret = CPUEV_RET_SCALL;
      else if (int'(e) == EV_DEBUG || (int'(e) >= EV_BUS_D && int'(e) <= EV_INTERRUPT_LEVEL_ZERO)
               || int'(e) == EV_BRK)
         ev_ret = CPUEV_RET_NEXT;
      else
         ev_ret = CPUEV_RET_FAULT;
   endfunction

   // Mask bits set when an event is accepted
   function automatic logic [MASK_W-1:0] ev_mask(input logic [RANK_W-1:0] e);
      logic [MASK_W-1:0] m;
      m = '0;
      case (int'(e))
         EV_INTERRUPT_LEVEL_THREE: m = MASK_W'(6'h2F);
         EV_INT2: m = MASK_W'(6'h27);
         EV_INT1: m = MASK_W'(6'h23);
         EV_INTERRUPT_LEVEL_ZERO: m = MASK_W'(6'h21);
         EV_RESET, EV_DEBUG: m = '0;
         default: m = MASK_W'(6'h3F);
      endcase
      ev_mask = m;
   endfunction

   logic [STAGES-1:0][NUM_EV-1:0] stage_pend;
   logic [STAGES-1:0] stage_any;
   logic [STAGES-1:0][RANK_W-1:0] stage_idx;
   logic [NUM_EV-1:0] async_pend;
   logic async_any;
   logic [RANK_W-1:0] async_idx;
   logic reset_seen;

   // mask gating: critical events ignore masks
   wire int_enable = !mask_in[MB_GLB];
   wire [3:0] irq_gated = irq_level_req & ~mask_in[MB_I3:MB_I0] & {4{int_enable}};

   // level three ranks above level zero
   always_comb begin
      async_pend = '0;
      async_pend[EV_RESET] = reset_seen;
      async_pend[EV_DEBUG] = on_chip_debug_stop & ~debug_mask;
      async_pend[EV_NMI] = nmi_req;
      async_pend[EV_INTERRUPT_LEVEL_THREE] = irq_gated[3];
      async_pend[EV_INT2] = irq_gated[2];
      async_pend[EV_INT1] = irq_gated[1];
      async_pend[EV_INTERRUPT_LEVEL_ZERO] = irq_gated[0];
   end

   wire exc_ok = !mask_in[MB_EXC] && !mask_in[MB_GLB];

   genvar g;
   generate
      for (g = 0; g < STAGES; g++) begin : g_stage
         wire v = stage_valid[g];
         wire chk = v & stage_mpu_check[g];
         wire f = stage_mpu_fetch[g];
         wire w = stage_mpu_write[g];
         always_comb begin
            stage_pend[g] = '0;
            stage_pend[g][EV_UNREC] = v & stage_unrec[g];
            stage_pend[g][EV_MULTI] = chk & stage_mpu_multi[g];
            stage_pend[g][EV_BUS_D] = v & stage_bus_err_d[g];
            stage_pend[g][EV_BUS_I] = v & stage_bus_err_i[g];
            stage_pend[g][EV_IADDR] = v & stage_iaddr[g] & exc_ok;
            // no region hit on fetch or data
            stage_pend[g][EV_IMISS] = chk & f & stage_mpu_nohit[g] & exc_ok;
            stage_pend[g][EV_IPROT] = chk & f & stage_mpu_denied[g] & exc_ok;
            stage_pend[g][EV_BRK] = v & stage_breakpoint[g] & exc_ok;
            stage_pend[g][EV_ILL] = v & stage_illegal[g] & exc_ok;
            stage_pend[g][EV_UNIMP] = v & stage_unimpl[g] & exc_ok;
            stage_pend[g][EV_PRIV] = v & stage_priv[g] & exc_ok;
            stage_pend[g][EV_COP] = v & stage_cop_absent[g] & exc_ok;
            stage_pend[g][EV_SCALL] = v & stage_scall[g];
            stage_pend[g][EV_DA_RD] = v & stage_daddr_rd[g] & exc_ok;
            stage_pend[g][EV_DA_WR] = v & stage_daddr_wr[g] & exc_ok;
            stage_pend[g][EV_DMISS_RD] = chk & ~f & ~w & stage_mpu_nohit[g] & exc_ok;
            stage_pend[g][EV_DMISS_WR] = chk & ~f & w & stage_mpu_nohit[g] & exc_ok;
            stage_pend[g][EV_DPROT_RD] = chk & ~f & ~w & stage_mpu_denied[g] & exc_ok;
            stage_pend[g][EV_DPROT_WR] = chk & ~f & w & stage_mpu_denied[g] & exc_ok;
            stage_pend[g][EV_FPU] = 1'b0;
            stage_pend[g][EV_DMOD] = 1'b0;
         end
         cpuev_pick #(.N(NUM_EV)) u_pick (
            .pend(stage_pend[g]),
            .any(stage_any[g]),
            .idx(stage_idx[g])
         );
      end
   endgenerate

   cpuev_pick #(.N(NUM_EV)) u_pick_async (
      .pend(async_pend),
      .any(async_any),
      .idx(async_idx)
   );

   // oldest stage wins; highest stage index is oldest
   logic sync_any;
   logic [RANK_W-1:0] sync_idx;
   logic [ADDR_W-1:0] sync_pc;
   logic [STAGES-1:0] sync_flush;
   always_comb begin
      sync_any = 1'b0;
      sync_idx = '0;
      sync_pc = '0;
      sync_flush = '0;
      for (int s = 0; s < STAGES; s++) begin
         if (stage_any[s]) begin
            sync_any = 1'b1;
            sync_idx = stage_idx[s];
            sync_pc = stage_pc[s*ADDR_W +: ADDR_W];
            sync_flush = STAGES'((1 << (s + 1)) - 1);
         end
      end
   end

   // Asynchronous sources only preempt the oldest instruction when they outrank it
   wire use_async = async_any && (!sync_any || async_idx < sync_idx);
   wire sel_any = use_async || sync_any;
   wire [RANK_W-1:0] sel_idx = use_async ? async_idx : sync_idx;
   wire [ADDR_W-1:0] sel_pc = use_async ? next_unfinished_pc : sync_pc;
   wire cpuev_ret_t sel_ret = ev_ret(sel_idx);
   wire sel_is_irq = int'(sel_idx) >= EV_INTERRUPT_LEVEL_THREE && int'(sel_idx) <= EV_INTERRUPT_LEVEL_ZERO;

   wire [ADDR_W-1:0] irq_off32 = {{(ADDR_W - AUTOVEC_W){1'b0}}, irq_offset};
   wire [ADDR_W-1:0] sel_off = sel_is_irq ? irq_off32 : ev_offset(sel_idx);
   wire [ADDR_W-1:0] vec_addr = event_vector_base | sel_off;
   wire [ADDR_W-1:0] next_target = (int'(sel_idx) == EV_RESET) ? RESET_ADDR :
                                   (int'(sel_idx) == EV_DEBUG) ? on_chip_debug_entry :
                                   vec_addr;
   wire [ADDR_W-1:0] next_ret = (sel_ret == CPUEV_RET_SCALL) ? sel_pc + SCALL_RET_INC :
                                (sel_ret == CPUEV_RET_NEXT) ? next_unfinished_pc :
                                (sel_ret == CPUEV_RET_FAULT) ? sel_pc : '0;

   // one-cycle redirect with address, return and mask
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reset_seen <= 1'b1;
         redirect <= 1'b0;
         redirect_addr <= '0;
         return_addr <= '0;
         taken_event <= '0;
         mask_set <= '0;
         flush_stage <= '0;
      end else begin
         reset_seen <= 1'b0;
         redirect <= sel_any && !redirect;
         redirect_addr <= next_target;
         return_addr <= next_ret;
         taken_event <= sel_idx;
         mask_set <= (sel_any && !redirect) ? ev_mask(sel_idx) : '0;
         flush_stage <= (sel_any && !redirect) ? (use_async ? '1 : sync_flush) : '0;
      end
   end

   localparam logic [RANK_W-1:0] RQ_RESET_IDX = RANK_W'(EV_RESET);
   localparam logic [RANK_W-1:0] RQ_SCALL_IDX = RANK_W'(EV_SCALL);
   localparam logic [RANK_W-1:0] RQ_MULTI_IDX = RANK_W'(EV_MULTI);
   localparam logic [RANK_W-1:0] RQ_INTERRUPT_LEVEL_THREE_IDX = RANK_W'(EV_INTERRUPT_LEVEL_THREE);
   localparam logic [RANK_W-1:0] RQ_INTERRUPT_LEVEL_ZERO_IDX = RANK_W'(EV_INTERRUPT_LEVEL_ZERO);

   a_reset_entry: assert property (@(posedge clk) disable iff (!rst_n)
      redirect && taken_event == RQ_RESET_IDX |-> redirect_addr == RESET_ADDR)
      else $error("reset entry wrong");

   a_scall_entry: assert property (@(posedge clk) disable iff (!rst_n)
      redirect && taken_event == RQ_SCALL_IDX |->
      redirect_addr == ($past(event_vector_base) | OFF_SCALL))
      else $error("scall entry wrong");
   a_scall_return: assert property (@(posedge clk) disable iff (!rst_n)
      redirect && taken_event == RQ_SCALL_IDX |->
      return_addr == 32'($past(sel_pc) + SCALL_RET_INC))
      else $error("scall return wrong");
   a_irq_autovec: assert property (@(posedge clk) disable iff (!rst_n)
      redirect && taken_event >= RQ_INTERRUPT_LEVEL_THREE_IDX && taken_event <= RQ_INTERRUPT_LEVEL_ZERO_IDX |->
      redirect_addr == ($past(event_vector_base) | {18'h0, $past(irq_offset)}))
      else $error("autovector address wrong");
   a_multi_hit: assert property (@(posedge clk) disable iff (!rst_n)
      redirect && taken_event == RQ_MULTI_IDX |->
      redirect_addr == ($past(event_vector_base) | OFF_MULTI))
      else $error("multiple hit entry wrong");
   sequence s_take;
      redirect;
   endsequence
   sequence s_gap;
      !redirect;
   endsequence
   a_single_redirect: assert property (@(posedge clk) disable iff (!rst_n)
      s_take |=> s_gap)
      else $error("redirect longer than one cycle");
   a_unused_slots: assert property (@(posedge clk) disable iff (!rst_n)
      redirect |-> taken_event != RANK_W'(EV_FPU) && taken_event != RANK_W'(EV_DMOD))
      else $error("unused slot raised");
   a_irq_masked: assert property (@(posedge clk) disable iff (!rst_n)
      redirect && taken_event == RQ_INTERRUPT_LEVEL_THREE_IDX |-> mask_set == MASK_W'(6'h2F))
      else $error("interrupt mask not set");
   a_nmi_unmasked: assert property (@(posedge clk) disable iff (!rst_n)
      nmi_req && !redirect && !sync_any && !async_pend[EV_RESET] && !async_pend[EV_DEBUG]
      |=> redirect)
      else $error("nmi not taken");
   a_oldest_first: assert property (@(posedge clk) disable iff (!rst_n)
      !redirect && stage_any[STAGES-1] && !use_async |=>
      redirect && taken_event == $past(stage_idx[STAGES-1]))
      else $error("oldest instruction not first");
endmodule // cpuev_entry

// *** cpuev_src_model.sv ***
// Model of the interrupt controller, debug system and NMI source
`timescale 1ns/1ps
module cpuev_src_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic redirect,
   input wire logic [cpuev_pkg::RANK_W-1:0] taken_event,
   input wire logic [cpuev_pkg::MASK_W-1:0] mask_in,
   input wire logic post_nmi,
   input wire logic [3:0] post_irq,
   input wire logic post_dbg,
   input wire logic [cpuev_pkg::AUTOVEC_W-1:0] base_off,
   input wire logic [cpuev_pkg::ADDR_W-1:0] dbg_addr,
   output logic nmi_req,
   output logic [3:0] irq_level_req,
   output logic [cpuev_pkg::AUTOVEC_W-1:0] irq_offset,
   output logic on_chip_debug_stop,
   output logic [cpuev_pkg::ADDR_W-1:0] on_chip_debug_entry
);
   import cpuev_pkg::*;
   logic [AUTOVEC_W-1:0] last_off;
   logic [ADDR_W-1:0] last_entry;
   logic [1:0] lvl;
   logic found;
   wire acc_nmi = redirect && taken_event == RANK_W'(EV_NMI);
   wire acc_dbg = redirect && taken_event == RANK_W'(EV_DEBUG);
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         nmi_req <= 1'b0;
         irq_level_req <= 4'h0;
         on_chip_debug_stop <= 1'b0;
         last_off <= '0;
         last_entry <= '0;
      end else begin
         nmi_req <= post_nmi | (nmi_req & !acc_nmi);
         on_chip_debug_stop <= post_dbg | (on_chip_debug_stop & !acc_dbg);
         for (int l = 0; l < 4; l++) begin
            irq_level_req[l] <= post_irq[l] |
               (irq_level_req[l] & !(redirect && taken_event == RANK_W'(EV_INTERRUPT_LEVEL_ZERO - l)));
         end
         last_off <= irq_offset;
         last_entry <= on_chip_debug_entry;
      end
   end
   always_comb begin
      lvl = 2'h0;
      found = 1'b0;
      for (int l = 0; l < 4; l++) begin
         if (irq_level_req[l] && !mask_in[l]) begin
            lvl = 2'(l);
            found = 1'b1;
         end
      end
   end
   // Idle lines toggle so a stale value is never read
   assign irq_offset = found ? {base_off[13:4], lvl, 2'h0} : ~last_off;
   assign on_chip_debug_entry = on_chip_debug_stop ? dbg_addr : ~last_entry;
endmodule // cpuev_src_model

// *** test_cpu_event_entry_priority.sv ***
// Self-checking bench for the event entry unit
`timescale 1ns/1ps
module test_cpu_event_entry_priority;
   import cpuev_pkg::*;
   localparam int S = 3;
   localparam logic [NUM_EV-1:0] STAGE_M = 28'h07B_C834;
   localparam logic [NUM_EV-1:0] MPU_M = 28'h780_3008;
   localparam logic [NUM_EV-1:0] ALL_M = STAGE_M | MPU_M;
   localparam logic [NUM_EV-1:0] UNMASK_M = 28'h010_003C;
   localparam int MPU_EV [7] = '{EV_MULTI, EV_IMISS, EV_IPROT, EV_DMISS_RD, EV_DMISS_WR,
      EV_DPROT_RD, EV_DPROT_WR};
   localparam logic [31:0] OFFS [NUM_EV] = '{0, 0, OFF_UNREC, OFF_MULTI, OFF_BUS_D, OFF_BUS_I,
      OFF_NMI, 0, 0, 0, 0, OFF_IADDR, OFF_IMISS, OFF_IPROT, OFF_BRK, OFF_ILL, OFF_UNIMP,
      OFF_PRIV, OFF_FPU, OFF_COP, OFF_SCALL, OFF_DA_RD, OFF_DA_WR, OFF_DMISS_RD,
      OFF_DMISS_WR, OFF_DPROT_RD, OFF_DPROT_WR, OFF_DMOD};
   logic clk, rst_n, dbg_mask, post_nmi, post_dbg, p_nmi, p_dbg;
   logic [31:0] evb, nup, dbg_addr;
   logic [S*32-1:0] pcs;
   logic [S-1:0] vld, v;
   logic [S-1:0][NUM_EV-1:0] evs, e;
   logic [5:0] mask_in;
   logic [3:0] post_irq, p_irq;
   logic [13:0] base_off;
   logic nmi_req, on_chip_debug_stop, redirect;
   logic [3:0] irq_level_req;
   logic [13:0] irq_offset;
   logic [31:0] on_chip_debug_entry, redirect_addr, return_addr;
   logic [4:0] taken_event;
   logic [5:0] mask_set;
   logic [S-1:0] flush_stage;
   int n_errors, samples_checked, s;

   function automatic logic [NUM_EV-1:0] b(int i);
      return 28'h1 << i;
   endfunction
   function automatic logic [S-1:0] col(logic [S-1:0][NUM_EV-1:0] x, logic [NUM_EV-1:0] m);
      for (int k = 0; k < S; k++) col[k] = |(x[k] & m);
   endfunction

   cpuev_entry #(.STAGES(S)) i_cpuev_entry (.clk(clk), .rst_n(rst_n), .event_vector_base(evb),
      .stage_valid(vld), .stage_pc(pcs), .stage_illegal(col(evs, b(EV_ILL))),
      .stage_unimpl(col(evs, b(EV_UNIMP))), .stage_priv(col(evs, b(EV_PRIV))),
      .stage_cop_absent(col(evs, b(EV_COP))), .stage_scall(col(evs, b(EV_SCALL))),
      .stage_iaddr(col(evs, b(EV_IADDR))), .stage_daddr_rd(col(evs, b(EV_DA_RD))),
      .stage_daddr_wr(col(evs, b(EV_DA_WR))), .stage_unrec(col(evs, b(EV_UNREC))),
      .stage_breakpoint(col(evs, b(EV_BRK))), .stage_mpu_check(col(evs, MPU_M)),
      .stage_mpu_fetch(col(evs, b(EV_IMISS) | b(EV_IPROT))),
      .stage_mpu_write(col(evs, b(EV_DMISS_WR) | b(EV_DPROT_WR))),
      .stage_mpu_nohit(col(evs, b(EV_IMISS) | b(EV_DMISS_RD) | b(EV_DMISS_WR))),
      .stage_mpu_multi(col(evs, b(EV_MULTI))),
      .stage_mpu_denied(col(evs, b(EV_IPROT) | b(EV_DPROT_RD) | b(EV_DPROT_WR))),
      .stage_bus_err_d(col(evs, b(EV_BUS_D))), .stage_bus_err_i(col(evs, b(EV_BUS_I))),
      .next_unfinished_pc(nup), .nmi_req(nmi_req), .irq_level_req(irq_level_req),
      .irq_offset(irq_offset), .on_chip_debug_stop(on_chip_debug_stop),
      .on_chip_debug_entry(on_chip_debug_entry), .mask_in(mask_in), .debug_mask(dbg_mask),
      .redirect(redirect), .redirect_addr(redirect_addr), .return_addr(return_addr),
      .taken_event(taken_event), .mask_set(mask_set), .flush_stage(flush_stage));

   cpuev_src_model i_cpuev_src_model (.clk(clk), .rst_n(rst_n), .redirect(redirect),
      .taken_event(taken_event), .mask_in(mask_in), .post_nmi(post_nmi), .post_irq(post_irq),
      .post_dbg(post_dbg), .base_off(base_off), .dbg_addr(dbg_addr), .nmi_req(nmi_req),
      .irq_level_req(irq_level_req), .irq_offset(irq_offset),
      .on_chip_debug_stop(on_chip_debug_stop), .on_chip_debug_entry(on_chip_debug_entry));

   always #5 clk = ~clk;

   task automatic stop_test();
      if (n_errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wait_redirect();
      int k;
      k = 0;
      do begin
         @(posedge clk);
         #1;
         k++;
      end while (redirect !== 1'b1 && k < 20);
      if (k >= 20) begin
         n_errors++;
         stop_test();
      end
   endtask
   // Rank model: returns the event index, or NUM_EV when nothing can be taken
   function automatic int pick(output int st);
      logic [NUM_EV-1:0] ok;
      int l;
      ok = (mask_in[4] | mask_in[5]) ? UNMASK_M : '1;
      st = -1;
      for (int k = 0; k < S; k++) if (vld[k] && (evs[k] & ok) != '0) st = k;
      for (int i = 0; i < NUM_EV; i++) begin
         l = EV_INTERRUPT_LEVEL_ZERO - i;
         if (i == EV_DEBUG && p_dbg && !dbg_mask) return i;
         if (i == EV_NMI && p_nmi) return i;
         if (l >= 0 && l < 4 && p_irq[l] && !mask_in[l] && !mask_in[5]) return i;
         if (st >= 0 && evs[st][i] && ok[i]) return i;
      end
      return NUM_EV;
   endfunction
   task automatic expect_one(int i, int st);
      logic [31:0] a, r;
      logic [5:0] ms;
      logic [S-1:0] fl;
      int l, sx;
      l = EV_INTERRUPT_LEVEL_ZERO - i;
      sx = (st < 0) ? 0 : st;
      a = evb | OFFS[i];
      r = pcs[sx*32+:32];
      ms = 6'h3F;
      fl = S'((1 << (sx + 1)) - 1);
      if (i == EV_SCALL) r = r + SCALL_RET_INC;
      if (i inside {EV_DEBUG, EV_BUS_D, EV_BUS_I, EV_NMI, EV_BRK} || (l >= 0 && l < 4)) r = nup;
      if (i inside {EV_DEBUG, EV_NMI} || (l >= 0 && l < 4)) fl = '1;
      if (l >= 0 && l < 4) begin
         a = evb | {18'h0, base_off[13:4], 2'(l), 2'h0};
         ms = 6'h20 | 6'((2 << l) - 1);
      end
      if (i == EV_DEBUG) begin
         a = dbg_addr;
         ms = 6'h00;
      end
      check("entry address", redirect_addr, a);
      check("return address", return_addr, r);
      check("taken event", 32'(taken_event), 32'(i));
      check("mask set", 32'(mask_set), 32'(ms));
      check("flush", 32'(flush_stage), 32'(fl));
   endtask
   task automatic fire(logic [S-1:0][NUM_EV-1:0] x, logic [S-1:0] xv, logic [5:0] m, logic dm,
         logic pn, logic [3:0] pi, logic pd);
      int i, st;
      @(posedge clk);
      post_nmi <= pn;
      post_irq <= pi;
      post_dbg <= pd;
      p_nmi |= pn;
      p_irq |= pi;
      p_dbg |= pd;
      @(posedge clk);
      post_nmi <= 1'b0;
      post_irq <= 4'h0;
      post_dbg <= 1'b0;
      evs <= x;
      vld <= xv;
      mask_in <= m;
      dbg_mask <= dm;
      evb <= $urandom;
      nup <= $urandom;
      pcs <= {$urandom, $urandom, $urandom};
      #1;
      for (int n = 0; n < 8; n++) begin
         i = pick(st);
         if (i == NUM_EV) break;
         wait_redirect();
         expect_one(i, st);
         @(posedge clk);
         if (i == EV_DEBUG) p_dbg = 1'b0;
         else if (i == EV_NMI) p_nmi = 1'b0;
         else if (i >= EV_INTERRUPT_LEVEL_THREE && i <= EV_INTERRUPT_LEVEL_ZERO) p_irq[EV_INTERRUPT_LEVEL_ZERO - i] = 1'b0;
         else begin
            evs <= '0;
            vld <= '0;
         end
         #1;
      end
      repeat (3) begin
         @(posedge clk);
         #1;
         check("idle redirect", 32'(redirect), 32'h0);
      end
   endtask

   initial begin
      {clk, rst_n, dbg_mask, post_nmi, post_dbg, p_nmi, p_dbg} = '0;
      {evb, nup, pcs, vld, evs, mask_in, post_irq, p_irq} = '0;
      {n_errors, samples_checked} = '0;
      void'($urandom(12));
      base_off = 14'($urandom) | 14'h2000;
      dbg_addr = $urandom;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      wait_redirect();
      check("reset entry", redirect_addr, RESET_ADDR);
      check("reset rank", 32'(taken_event), 32'(EV_RESET));
      check("reset return", return_addr, 32'h0000_0000);
      for (int i = 0; i < NUM_EV; i++) begin
         if (ALL_M[i]) begin
            s = $urandom % S;
            e = '0;
            e[s][i] = 1'b1;
            fire(e, S'(1 << s), 6'h00, 1'b0, 1'b0, 4'h0, 1'b0);
         end
      end
      e = '0;
      e[0] = b(EV_ILL);
      fire(e, 3'h1, 6'h00, 1'b0, 1'b1, 4'hF, 1'b1);
      e[0] = b(EV_ILL) | b(EV_SCALL);
      fire(e, 3'h1, 6'h30, 1'b1, 1'b1, 4'hF, 1'b1);
      fire('0, 3'h0, 6'h00, 1'b0, 1'b0, 4'h0, 1'b0);
      for (int n = 0; n < 40; n++) begin
         v = 3'($urandom);
         for (int k = 0; k < S; k++) begin
            e[k] = v[k] ? (28'($urandom & $urandom) & STAGE_M) : '0;
            if (v[k] && $urandom % 2) e[k][MPU_EV[$urandom % 7]] = 1'b1;
         end
         fire(e, v, 6'($urandom & $urandom), 1'($urandom), ($urandom % 3) == 0,
            4'($urandom & $urandom), ($urandom % 4) == 0);
      end
      stop_test();
   end
endmodule // test_cpu_event_entry_priority
